// ---- core/acv_ctrl.sv ----
// Conversion sequencer of a successive-approximation converter:
// clock select/divide, sample and approximation phases, compare and
// result transfer. Assumes an analog core that answers comp_above for
// the trial code and a power controller on the same clock.
`timescale 1ns/10ps
module acv_ctrl
  import acv_pkg::*;
#(
  parameter int ASYNC_DIV = 4 // mclk cycles per internal osc period
) (
  input  wire logic        mclk,
  input  wire logic        srst,
  input  wire logic [2:0]  addr,
  input  wire logic [7:0]  wr_data,
  input  wire logic        wr_stb,
  input  wire logic        rd_stb,
  output logic      [7:0]  rd_data,
  output logic             irq,
  input  wire logic        hw_trig_pin,
  input  wire logic        alt_clk_pin,
  input  wire logic        comp_above,
  input  wire logic        stop3_mode,
  input  wire logic        stop12_mode,
  output logic             sample_on,
  output logic             conv_active,
  output logic      [11:0] dac_code,
  output logic      [4:0]  channel
);

  logic [7:0]  c1_q, c2_q, cfg_q, cvh_q, cvl_q, rd_q;
  logic [11:0] sar_q, bit_q, res_q;
  logic [4:0]  ph_q;
  logic [9:0]  cyc_q;
  logic [3:0]  osc_q;
  logic [2:0]  div_q, trg_q, alt_q;
  logic        flag_q, hi_rd_q, irq_q, half_q, act_q;
  acv_state_t  st_q;

  // Stop1/stop2 behaves as a full reset
  // deep stop reset
  wire rst_all = srst | stop12_mode;

  // Configuration decode
  wire [1:0] src   = cfg_q[1:0];
  wire [1:0] div   = cfg_q[CFG_DIV+:2];
  wire       is8   = cfg_q[CFG_MODE+:2] == MODE_8B;
  wire       async = src == SRC_ASYNC;
  wire       cont  = c1_q[C1_CONT];
  wire       halt  = stop3_mode & ~async;
  wire [4:0] samp_lim = cfg_q[CFG_LONG] ? SAMP_LONG : SAMP_SHORT;
  wire [4:0] appr_lim = is8 ? APPROX_8B : APPROX_HI;
  wire [11:0] lsb     = is8 ? 12'h008 : 12'h001;

  // Pin synchronisers; stage 0 feeds only stage 1
  always_ff @(posedge mclk) begin
    if (rst_all) begin
      trg_q <= 3'h0;
      alt_q <= 3'h0;
    end else begin
      trg_q <= {trg_q[1:0], hw_trig_pin};
      alt_q <= {alt_q[1:0], alt_clk_pin};
    end
  end
  wire trig_rise = trg_q[1] & ~trg_q[2];
  wire alt_edge  = alt_q[1] & ~alt_q[2];

  // Register writes; any config write aborts a conversion
  always_ff @(posedge mclk) begin
    if (rst_all) begin
      c1_q  <= CTRL1_RST;
      c2_q  <= REG_RST;
      cfg_q <= REG_RST;
      cvh_q <= REG_RST;
      cvl_q <= REG_RST;
    end else if (wr_stb) begin
      case (addr)
        A_CTRL1: c1_q  <= {1'b0, wr_data[6:0]};
        A_CTRL2: c2_q  <= {1'b0, wr_data[6:4], 4'h0};
        A_CVH:   cvh_q <= {4'h0, wr_data[3:0]};
        A_CVL:   cvl_q <= wr_data;
        A_CFG:   cfg_q <= wr_data;
        default: ;
      endcase
    end
  end

  wire wr_abort = wr_stb & (addr != A_RESH) & (addr != A_RESL) & (addr != 3'h7);
  wire sw_start = wr_stb & (addr == A_CTRL1) & (wr_data[4:0] != CH_OFF) & ~c2_q[C2_HWT];
  // Edges while busy are ignored
  wire hw_start = trig_rise & c2_q[C2_HWT] & (st_q == ST_IDLE) & (c1_q[4:0] != CH_OFF)
                  & ~halt & ~wr_abort;

  // Internal asynchronous oscillator and bus/2 enable
  wire osc_en = async & (osc_q == 4'(ASYNC_DIV - 1));
  always_ff @(posedge mclk) begin
    if (rst_all) begin
      half_q <= 1'b0;
      osc_q  <= 4'h0;
    end else begin
      half_q <= ~half_q;
      osc_q  <= (!async || osc_en) ? 4'h0 : osc_q + 4'h1;
    end
  end

  // Source select; wait mode changes nothing here
  // sources usable in wait
  logic src_en;
  always_comb begin
    case (src)
      SRC_BUS:  src_en = 1'b1;
      SRC_BUS2: src_en = half_q;
      SRC_ALT:  src_en = alt_edge;
      default:  src_en = osc_en;
    endcase
  end

  // Divide by 1/2/4/8 into a conversion clock enable
  // programmable divider
  wire [2:0] dmask  = {div == 2'h3, div[1], div != 2'h0};
  wire       tick   = src_en & ~halt;
  wire       conversion_clock_en = tick & (div_q == dmask);
  always_ff @(posedge mclk) begin
    if (rst_all) begin
      div_q <= 3'h0;
    end else if (tick) begin
      div_q <= (div_q >= dmask) ? 3'h0 : div_q + 3'h1;
    end
  end

  // Compare: result plus two's complement of compare value
  logic [11:0] conv_val;
  wire [10:0] r10 = {1'b0, sar_q[11:2]} + {10'h000, sar_q[1]};
  wire [8:0]  r8  = {1'b0, sar_q[11:4]} + {8'h00, sar_q[3]};
  always_comb begin
    case (cfg_q[CFG_MODE+:2])
      MODE_8B: conv_val = {4'h0, r8[8] ? 8'hff : r8[7:0]};
      2'h2:    conv_val = {2'h0, r10[10] ? 10'h3ff : r10[9:0]};
      default: conv_val = sar_q;
    endcase
  end
  wire [11:0] cv   = {cvh_q[3:0], cvl_q};
  wire [12:0] diff = {1'b0, conv_val} + ~{1'b0, cv} + 13'h0001;
  wire cmp_ok   = c2_q[C2_GT] ? ~diff[12] : diff[12];
  wire cmp_fail = c2_q[C2_CMPEN] & ~cmp_ok;
  wire blocked  = hi_rd_q & ~is8;
  wire do_xfer  = (st_q == ST_XFER) & ~cmp_fail & ~blocked & ~halt;
  // A blocked transfer retries unless the compare already failed
  wire go_again = cont | (blocked & ~cmp_fail);

  // Sequencer. Sample and phase lengths are exact in mclk only when
  // the bus runs at least as fast as the conversion clock.
  // no slow-bus compensation
  always_ff @(posedge mclk) begin
    if (rst_all) begin
      st_q  <= ST_IDLE;
      ph_q  <= 5'h00;
      cyc_q <= 10'h000;
    end else if (sw_start || hw_start) begin
      st_q  <= ST_SETUP;
      ph_q  <= 5'h00;
      cyc_q <= async ? 10'(BUS_SETUP_CYC + STARTUP_CYC) : 10'(BUS_SETUP_CYC);
    end else if (wr_abort || halt) begin
      st_q <= ST_IDLE;
      ph_q <= 5'h00;
    end else begin
      case (st_q)
        ST_SETUP: begin
          if (cyc_q != 10'h000) begin
            cyc_q <= cyc_q - 10'h001;
          end else if (conversion_clock_en) begin
            if (ph_q == FIRST_CONVERSION_CLOCK - 5'h01) begin
              st_q <= ST_SAMPLE;
              ph_q <= 5'h00;
            end else begin
              ph_q <= ph_q + 5'h01;
            end
          end
        end
        ST_SAMPLE: begin
          if (conversion_clock_en) begin
            if (ph_q == samp_lim - 5'h01) begin
              st_q <= ST_APPROX;
              ph_q <= 5'h00;
            end else begin
              ph_q <= ph_q + 5'h01;
            end
          end
        end
        ST_APPROX: begin
          if (conversion_clock_en) begin
            if (ph_q == appr_lim - 5'h01) begin
              st_q <= ST_XFER;
              ph_q <= 5'h00;
            end else begin
              ph_q <= ph_q + 5'h01;
            end
          end
        end
        ST_XFER: begin
          ph_q <= 5'h00;
          st_q <= go_again ? ST_SAMPLE : ST_IDLE;
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end

  // Successive approximation; trial bit walks down to lsb
  // approximate after sampling
  wire [11:0] nxt  = bit_q >> 1;
  wire        step = (st_q == ST_APPROX) & conversion_clock_en & (bit_q >= lsb);
  always_ff @(posedge mclk) begin
    if (rst_all) begin
      sar_q <= 12'h000;
      bit_q <= 12'h000;
    end else if (st_q == ST_SAMPLE && conversion_clock_en && ph_q == samp_lim - 5'h01) begin
      sar_q <= 12'h800;
      bit_q <= 12'h800;
    end else if (step) begin
      sar_q <= (comp_above ? sar_q : sar_q & ~bit_q) | ((nxt >= lsb) ? nxt : 12'h000);
      bit_q <= nxt;
    end
  end

  // Result, completion flag and read-order tracking; set beats clear
  wire flag_clr = (rd_stb & (addr == A_RESL)) | (wr_stb & (addr == A_CTRL1));
  always_ff @(posedge mclk) begin
    if (rst_all) begin
      res_q   <= 12'h000;
      flag_q  <= 1'b0;
      hi_rd_q <= 1'b0;
    end else begin
      if (do_xfer) begin
        res_q <= c2_q[C2_CMPEN] ? diff[11:0] : conv_val;
      end
      if (do_xfer) begin
        flag_q <= 1'b1;
      end else if (flag_clr) begin
        flag_q <= 1'b0;
      end
      if (rd_stb && addr == A_RESH && !is8) begin
        hi_rd_q <= 1'b1;
      end else if (rd_stb && addr == A_RESL) begin
        hi_rd_q <= 1'b0;
      end
    end
  end

  // Interrupt tracks flag and enable, one cycle later
  // raise on flag
  always_ff @(posedge mclk) begin
    if (rst_all) begin
      irq_q <= 1'b0;
      act_q <= 1'b0;
    end else begin
      irq_q <= flag_q & c1_q[C1_IEN];
      act_q <= st_q != ST_IDLE;
    end
  end

  // Read data valid only in the cycle after the strobe
  always_ff @(posedge mclk) begin
    if (rst_all || !rd_stb) begin
      rd_q <= 8'h00;
    end else begin
      case (addr)
        A_CTRL1: rd_q <= {flag_q, c1_q[6:0]};
        A_CTRL2: rd_q <= {st_q != ST_IDLE, c2_q[6:0]};
        A_RESH:  rd_q <= is8 ? 8'h00 : {4'h0, res_q[11:8]};
        A_RESL:  rd_q <= res_q[7:0];
        A_CVH:   rd_q <= cvh_q;
        A_CVL:   rd_q <= cvl_q;
        A_CFG:   rd_q <= cfg_q;
        default: rd_q <= 8'h00;
      endcase
    end
  end

  assign rd_data     = rd_q;
  assign irq         = irq_q;
  assign sample_on   = st_q[2];
  assign conv_active = act_q;
  assign dac_code    = sar_q;
  assign channel     = c1_q[4:0];

  // Checks; helper counts conversion clocks spent sampling
  logic [4:0] smp_cnt_q;
  always_ff @(posedge mclk) begin
    if (rst_all || st_q != ST_SAMPLE) begin
      smp_cnt_q <= 5'h00;
    end else if (conversion_clock_en) begin
      smp_cnt_q <= smp_cnt_q + 5'h01;
    end
  end
  wire abort_any = sw_start | hw_start | wr_abort | halt;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst_all);

  samp_len_a: assert property ($rose(st_q == ST_APPROX) |-> $past(smp_cnt_q) == samp_lim - 5'h01)
    else $error("sample phase length wrong");
  isolate_a: assert property ((st_q == ST_SAMPLE && conversion_clock_en && ph_q == samp_lim - 5'h01 && !abort_any)
    |=> !sample_on && st_q == ST_APPROX && sar_q == 12'h800)
    else $error("approximation did not follow sampling");
  res_hold_a: assert property ($changed(res_q) && !$past(rst_all) |-> $past(st_q) == ST_XFER)
    else $error("result changed outside transfer");
  cmp_diff_a: assert property (do_xfer && c2_q[C2_CMPEN] |=> res_q == $past(diff[11:0]) && flag_q)
    else $error("compare difference not stored");
  cmp_miss_a: assert property ((st_q == ST_XFER && cmp_fail && !flag_q) |=> !flag_q && $stable(res_q))
    else $error("failed compare changed state");
  irq_set_a: assert property ($rose(flag_q) && c1_q[C1_IEN] && !wr_stb |=> irq)
    else $error("interrupt not raised");
  irq_clr_a: assert property (!flag_q |=> !irq)
    else $error("interrupt without flag");
  stop3_a: assert property (halt && !sw_start |=> st_q == ST_IDLE && $stable(res_q))
    else $error("stop3 did not abort");
  block_a: assert property ((st_q == ST_XFER && blocked && !cmp_fail && !abort_any) |=> $stable(res_q)
    && st_q == ST_SAMPLE)
    else $error("blocked transfer went through");
  div8_a: assert property ((conversion_clock_en && div == 2'h3) |=> (!conversion_clock_en || div != 2'h3) [*7])
    else $error("divide by eight too fast");

  cmp_hit_c: cover property (do_xfer && c2_q[C2_CMPEN]);
  blocked_c: cover property (st_q == ST_XFER && blocked);
  cont_c: cover property (st_q == ST_XFER && cont ##1 st_q == ST_SAMPLE);
  stop3_run_c: cover property (stop3_mode && async && st_q == ST_APPROX);
endmodule

// ---- core/acv_pkg.sv ----
// Constants shared by the converter sequencer: register map, fields,
// reset values, mode codes, phase lengths and the FSM state type.
// Assumes a 100 MHz mclk and an 8-bit plain register port.
package acv_pkg;
  // Timing, mclk rate and startup of the internal asynchronous clock
  localparam int CLK_MHZ       = 100;
  localparam int STARTUP_NS    = 5000;
  localparam int STARTUP_CYC   = (STARTUP_NS * CLK_MHZ + 999) / 1000;
  localparam int BUS_SETUP_CYC = 5;
  // Phase lengths in conversion clock cycles
  localparam logic [4:0] FIRST_CONVERSION_CLOCK = 5'h03;
  localparam logic [4:0] SAMP_SHORT = 5'h04; // 3.5 rounded up
  localparam logic [4:0] SAMP_LONG  = 5'h18; // 23.5 rounded up
  localparam logic [4:0] APPROX_8B  = 5'h0d;
  localparam logic [4:0] APPROX_HI  = 5'h10;
  // Register addresses
  localparam logic [2:0] A_CTRL1 = 3'h0;
  localparam logic [2:0] A_CTRL2 = 3'h1;
  localparam logic [2:0] A_RESH  = 3'h2;
  localparam logic [2:0] A_RESL  = 3'h3;
  localparam logic [2:0] A_CVH   = 3'h4;
  localparam logic [2:0] A_CVL   = 3'h5;
  localparam logic [2:0] A_CFG   = 3'h6;
  // Field positions
  localparam int C1_FLAG  = 7;
  localparam int C1_IEN   = 6;
  localparam int C1_CONT  = 5;
  localparam int C2_ACT   = 7;
  localparam int C2_HWT   = 6;
  localparam int C2_CMPEN = 5;
  localparam int C2_GT    = 4;
  localparam int CFG_DIV  = 5;
  localparam int CFG_LONG = 4;
  localparam int CFG_MODE = 2;
  // Reset values and codes
  localparam logic [7:0] CTRL1_RST = 8'h1f;
  localparam logic [7:0] REG_RST   = 8'h00;
  localparam logic [4:0] CH_OFF    = 5'h1f;
  localparam logic [1:0] MODE_8B   = 2'h0;
  localparam logic [1:0] SRC_BUS   = 2'h0;
  localparam logic [1:0] SRC_BUS2  = 2'h1;
  localparam logic [1:0] SRC_ALT   = 2'h2;
  localparam logic [1:0] SRC_ASYNC = 2'h3;
  // Sequencer states, one-hot
  typedef enum logic [4:0] {
    ST_IDLE   = 5'b00001,
    ST_SETUP  = 5'b00010,
    ST_SAMPLE = 5'b00100,
    ST_APPROX = 5'b01000,
    ST_XFER   = 5'b10000
  } acv_state_t;
endpackage

// ---- tb/acv_afe_model.sv ----
// Analog side stand-in: input switch, sample hold and comparator.
// Assumes acv_ctrl drives sample_on and dac_code on the same mclk.
`timescale 1ns/10ps
module acv_afe_model (
  input  wire logic        mclk,
  input  wire logic        sample_on,
  input  wire logic [11:0] dac_code,
  input  wire logic [11:0] level,
  output logic             comp_above
);
  logic [11:0] held_q = 12'h000;

  // Input isolated after sampling
  // Later input changes must not reach the trial compare
  always_ff @(posedge mclk) begin
    if (sample_on) begin
      held_q <= level;
    end
  end

  // Input sits half a code above level, so an equal trial code is kept
  assign comp_above = (dac_code <= held_q);
endmodule

// ---- tb/acv_ctrl_tb.sv ----
// Bench for acv_ctrl: register port tasks, timing, compare, blocking
// and low-power cases. Assumes acv_afe_model as the analog side.
`timescale 1ns/10ps
module acv_ctrl_tb;
  import acv_pkg::*;
  logic        mclk;
  logic        srst;
  logic [2:0]  addr;
  logic [7:0]  wr_data;
  logic        wr_stb;
  logic        rd_stb;
  logic [7:0]  rd_data;
  logic        irq;
  logic        hw_trig_pin;
  logic        alt_clk_pin = 1'b0;
  logic        comp_above;
  logic        stop3_mode;
  logic        stop12_mode;
  logic        sample_on;
  logic        conv_active;
  logic [11:0] dac_code;
  logic [4:0]  channel;
  logic [11:0] level;
  logic [7:0]  d;
  int          err_count;
  int          cmp_count;
  int          cyc;
  int          cnt;
  int          sw;
  int          per;
  int          last;
  int          n;
  logic [7:0]  cf [6] = '{8'h00, 8'h20, 8'h40, 8'h60, 8'h01, 8'h02};
  logic [7:0]  mc [4] = '{8'h00, 8'h04, 8'h10, 8'h18};
  logic [15:0] mr [4] = '{16'h005a, 16'h05a4, 16'h005a, 16'h0169};

  acv_ctrl #(.ASYNC_DIV(1)) acv_ctrl_inst (
    .mclk(mclk), .srst(srst), .addr(addr), .wr_data(wr_data), .wr_stb(wr_stb),
    .rd_stb(rd_stb), .rd_data(rd_data), .irq(irq), .hw_trig_pin(hw_trig_pin),
    .alt_clk_pin(alt_clk_pin), .comp_above(comp_above), .stop3_mode(stop3_mode),
    .stop12_mode(stop12_mode), .sample_on(sample_on), .conv_active(conv_active),
    .dac_code(dac_code), .channel(channel)
  );
  acv_afe_model acv_afe_model_inst (
    .mclk(mclk), .sample_on(sample_on), .dac_code(dac_code), .level(level), .comp_above(comp_above)
  );

  // 100 MHz clock
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // Sample window width, start-to-start period, alt clock, hang guard
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    alt_clk_pin <= ~alt_clk_pin;
    if (sample_on) begin
      if (cnt == 0) begin
        per <= cyc - last;
        last <= cyc;
      end
      cnt <= cnt + 1;
    end else if (cnt != 0) begin
      sw <= cnt;
      cnt <= 0;
    end
    if (cyc == 20000) begin
      chk(16'h0001, 16'h0000);
      summarize();
    end
  end

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge mclk);
    addr <= a;
    wr_data <= v;
    wr_stb <= 1'b1;
    @(posedge mclk);
    wr_stb <= 1'b0;
  endtask

  // Read data stands only in the cycle after the strobe edge
  task automatic rd(input logic [2:0] a, output logic [7:0] v);
    @(posedge mclk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge mclk);
    rd_stb <= 1'b0;
    #1;
    v = rd_data;
  endtask

  // Bounded wait; n holds the edges counted
  task automatic wait_irq(input int lim);
    n = 0;
    while (irq !== 1'b1 && n < lim) begin
      @(posedge mclk);
      #1;
      n++;
    end
  endtask

  task automatic conv(input logic [7:0] cfg, input logic [7:0] c2, input logic [7:0] c1);
    wr(A_CFG, cfg);
    wr(A_CTRL2, c2);
    wr(A_CTRL1, c1);
    wait_irq(600);
  endtask

  // High then low, so no blocking is left behind
  task automatic res(input logic [15:0] exp);
    logic [7:0] h;
    rd(A_RESH, h);
    rd(A_RESL, d);
    chk({h, d}, exp);
    @(posedge mclk);
    #1;
    chk(irq, 1'b0);
  endtask

  task automatic regs_at_reset();
    for (int a = 0; a < 8; a++) begin
      rd(3'(a), d);
      chk(d, a == 0 ? CTRL1_RST : REG_RST);
    end
    chk(channel, CH_OFF);
  endtask

  function automatic int smp(input logic [7:0] c);
    return c[4] ? SAMP_LONG : SAMP_SHORT;
  endfunction

  function automatic int apx(input logic [7:0] c);
    return c[3:2] == MODE_8B ? APPROX_8B : APPROX_HI;
  endfunction

  // Main sequence
  initial begin
    srst = 1'b1;
    addr = 3'h0;
    wr_data = 8'h00;
    wr_stb = 1'b0;
    rd_stb = 1'b0;
    hw_trig_pin = 1'b0;
    stop3_mode = 1'b0;
    stop12_mode = 1'b0;
    level = 12'h5a4;
    repeat (10) @(posedge mclk);
    srst <= 1'b0;
    wr(3'h7, 8'hff);
    regs_at_reset();
    for (int i = 0; i < 4; i++) begin
      conv(mc[i], 8'h00, 8'h41);
      // Setup, first clocks, phases, transfer cycle, irq lag
      chk(16'(n), 16'(BUS_SETUP_CYC + FIRST_CONVERSION_CLOCK + smp(mc[i]) + apx(mc[i]) + 2));
      chk(sw, smp(mc[i]));
      res(mr[i]);
    end
    for (int i = 0; i < 6; i++) begin
      conv(cf[i], 8'h00, 8'h41);
      chk(sw, 16'(SAMP_SHORT) << (i < 4 ? i : 1));
      res(16'h005a);
    end
    // Compare 0x5a4 against 0x600, then 0x3a0
    wr(A_CVH, 8'h06);
    conv(8'h04, 8'h20, 8'h41);
    res(16'h0fa4);
    wr(A_CVH, 8'h03);
    wr(A_CVL, 8'ha0);
    conv(8'h04, 8'h30, 8'h41);
    res(16'h0204);
    conv(8'h04, 8'h20, 8'h41);
    chk(irq, 1'b0);
    res(16'h0204);
    for (int i = 0; i < 4; i++) begin
      conv(mc[i], 8'h00, 8'h61);
      repeat (3) @(posedge mclk);
      chk(per, smp(mc[i]) + apx(mc[i]) + 1);
      // Stop and clear the flag, so the next irq wait is not stale
      wr(A_CTRL1, 8'h1f);
      rd(A_RESL, d);
    end
    // Stop3 on a synchronous source aborts mid-sample
    wr(A_CTRL1, 8'h61);
    repeat (12) @(posedge mclk);
    stop3_mode <= 1'b1;
    repeat (4) @(posedge mclk);
    #1;
    chk({sample_on, conv_active}, 2'b00);
    stop3_mode <= 1'b0;
    wait_irq(100);
    chk(irq, 1'b0);
    res(16'h0169);
    // low byte read above, no blocking into stop3
    stop3_mode <= 1'b1;
    conv(8'h03, 8'h00, 8'h41);
    chk(16'(n), 16'(BUS_SETUP_CYC + STARTUP_CYC + FIRST_CONVERSION_CLOCK + SAMP_SHORT + APPROX_8B + 2));
    stop3_mode <= 1'b0;
    res(16'h005a);
    // Hardware trigger: the write alone must not start
    conv(8'h00, 8'h40, 8'h41);
    chk(irq, 1'b0);
    hw_trig_pin <= 1'b1;
    wait_irq(80);
    hw_trig_pin <= 1'b0;
    chk(irq, 1'b1);
    res(16'h005a);
    // High read with low unread holds off every transfer
    wr(A_CTRL2, 8'h00);
    wr(A_CFG, 8'h04);
    wr(A_CTRL1, 8'h41);
    rd(A_RESH, d);
    level <= 12'h123;
    wait_irq(60);
    chk(irq, 1'b0);
    rd(A_RESL, d);
    chk(d, 8'h5a);
    wait_irq(100);
    res(16'h0123);
    stop12_mode <= 1'b1;
    @(posedge mclk);
    stop12_mode <= 1'b0;
    regs_at_reset();
    summarize();
  end
endmodule
